// ==== host_endpoint_trigger_pipe_out.sv ====
// trigger-in, plain pipe-out, block pipe-out and buffered pipe-out endpoints
// assumes host control bus comes from another clock; user logic is on sys_clk
`timescale 1ns/100ps
// Function
// - triggers retimed into the endpoint clock
// - sixteen independent trigger bits
// - one fetch pulse per requested plain or block pipe word
// - push below full stores word, advances write position
// - full flag when fifo holds eight
// - empty flag when fifo holds none
// - four-bit fill level in sixteenths
// - control taken from 31-bit host bus
// - answers returned on 17-bit bus
module host_endpoint_trigger_pipe_out (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [30:0] host_ctrl_bus,
    output logic [16:0] endpoint_return_bus,
    output logic [15:0] host_trigger_bits,
    input wire logic [15:0] pipe_word_in,
    output logic pipe_word_fetch,
    input wire logic [15:0] block_word_in,
    output logic block_word_fetch,
    output logic block_begin_pulse,
    input wire logic block_data_ready,
    input wire logic [15:0] fifo_word_in,
    input wire logic fifo_push,
    output logic fifo_full_flag,
    output logic fifo_empty_flag,
    output logic [3:0] fifo_fill_level
);
    typedef enum logic [2:0] {st_idle, st_wait_ready, st_settle, st_take, st_drain} reply_e;

    logic [30:0] sync1;
    logic [30:0] sync2;
    logic [30:0] sync3;
    logic [30:0] ctrl;
    logic [30:0] ctrl_prev;
    logic [30:0] ctrl_change;
    logic [7:0] endpoint_address;
    logic pipe_req;
    logic bt_req;
    logic buf_req;
    reply_e state;
    logic from_block;
    logic [3:0] block_left;
    fifo_if fb();

    // ****************************************
    // control bus crossing
    // ****************************************
    // three stages; a bit counts only once stages two and three agree
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            ctrl <= '0;
            ctrl_prev <= '0;
        end
        else
        begin
            sync1 <= host_ctrl_bus;
            sync2 <= sync1;
            sync3 <= sync2;
            ctrl <= (sync2 & ~(sync2 ^ sync3)) | (ctrl & (sync2 ^ sync3));
            ctrl_prev <= ctrl;
        end
    end

    assign ctrl_change = ctrl ^ ctrl_prev;
    assign endpoint_address = ctrl[endpoint_pkg::ADDR_LSB +: endpoint_pkg::ADDR_W];
    assign pipe_req = ctrl_change[endpoint_pkg::PIPE_REQ_BIT] &&
        endpoint_address == endpoint_pkg::PIPE_ADDR;
    assign bt_req = ctrl_change[endpoint_pkg::BT_REQ_BIT] &&
        endpoint_address == endpoint_pkg::BT_ADDR;
    assign buf_req = ctrl_change[endpoint_pkg::BUF_REQ_BIT] &&
        endpoint_address == endpoint_pkg::BUF_ADDR;

    // ****************************************
    // trigger outputs
    // ****************************************
    // host toggles a line per trigger, so events survive the crossing
    for (genvar i = 0; i < endpoint_pkg::TRIG_W; i++)
    begin : g_trig
        always_ff @(posedge sys_clk)
        begin
            if (reset)
            begin
                host_trigger_bits[i] <= 1'b0;
            end
            else
            begin
                host_trigger_bits[i] <= ctrl_change[endpoint_pkg::TRIG_LSB + i];
            end
        end
    end

    // ****************************************
    // buffered pipe fifo
    // ****************************************
    assign fb.push = fifo_push;
    assign fb.push_data = fifo_word_in;
    assign fb.pop = state == st_drain && fb.pop_valid;

    word_fifo #(
        .WIDTH(endpoint_pkg::WORD_W),
        .DEPTH(endpoint_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .reset(reset),
        .f(fb)
    );

    assign fifo_full_flag = fb.full;
    assign fifo_empty_flag = fb.empty;
    assign fifo_fill_level = fb.level;

    // ****************************************
    // request and reply sequencer
    // ****************************************
    // one request at a time; a request landing while busy is dropped
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state <= st_idle;
            from_block <= 1'b0;
            block_left <= '0;
            pipe_word_fetch <= 1'b0;
            block_word_fetch <= 1'b0;
            block_begin_pulse <= 1'b0;
            endpoint_return_bus <= '0;
        end
        else
        begin
            pipe_word_fetch <= 1'b0;
            block_word_fetch <= 1'b0;
            block_begin_pulse <= 1'b0;
            unique case (state)
                st_idle:
                begin
                    if (pipe_req)
                    begin
                        pipe_word_fetch <= 1'b1;
                        from_block <= 1'b0;
                        state <= st_settle;
                    end
                    else if (bt_req && block_left == '0)
                    begin
                        state <= st_wait_ready;
                    end
                    else if (bt_req)
                    begin
                        block_word_fetch <= 1'b1;
                        block_left <= block_left - 1'b1;
                        from_block <= 1'b1;
                        state <= st_settle;
                    end
                    else if (buf_req)
                    begin
                        state <= st_drain;
                    end
                end
                st_wait_ready:
                begin
                    // a block starts only when the user can feed all of it
                    if (block_data_ready)
                    begin
                        block_begin_pulse <= 1'b1;
                        block_word_fetch <= 1'b1;
                        block_left <= endpoint_pkg::BLOCK_WORDS - 1'b1;
                        from_block <= 1'b1;
                        state <= st_settle;
                    end
                end
                st_settle:
                begin
                    // user word only lands in the cycle after the fetch pulse
                    state <= st_take;
                end
                st_take:
                begin
                    endpoint_return_bus[15:0] <= from_block ? block_word_in : pipe_word_in;
                    endpoint_return_bus[endpoint_pkg::ACK_BIT] <=
                        !endpoint_return_bus[endpoint_pkg::ACK_BIT];
                    state <= st_idle;
                end
                st_drain:
                begin
                    // an empty fifo answers with a zero word
                    endpoint_return_bus[15:0] <= fb.pop_valid ? fb.pop_data :
                        endpoint_pkg::EMPTY_WORD;
                    endpoint_return_bus[endpoint_pkg::ACK_BIT] <=
                        !endpoint_return_bus[endpoint_pkg::ACK_BIT];
                    state <= st_idle;
                end
            endcase
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_fetch_one;
        @(posedge sys_clk) disable iff (reset)
        pipe_word_fetch |=> !pipe_word_fetch;
    endproperty
    a_fetch_one: assert property (p_fetch_one) else $error("fetch longer than a cycle");

    property p_word_next;
        @(posedge sys_clk) disable iff (reset)
        pipe_word_fetch |=> ##1 endpoint_return_bus[15:0] == $past(pipe_word_in);
    endproperty
    a_word_next: assert property (p_word_next) else $error("word not taken after fetch");

    property p_trig_cause;
        @(posedge sys_clk) disable iff (reset)
        host_trigger_bits != 16'h0000 |-> $past(ctrl_change[15:0]) == host_trigger_bits;
    endproperty
    a_trig_cause: assert property (p_trig_cause) else $error("trigger without cause");

    property p_trig_sync;
        @(posedge sys_clk) disable iff (reset)
        sync2[0] == sync3[0] && sync2[0] != ctrl[0] |=> ctrl[0] == $past(sync2[0]);
    endproperty
    a_trig_sync: assert property (p_trig_sync) else $error("trigger crossing stuck");

    property p_begin_ready;
        @(posedge sys_clk) disable iff (reset)
        block_begin_pulse |-> block_word_fetch && $past(block_data_ready);
    endproperty
    a_begin_ready: assert property (p_begin_ready) else $error("block began unready");

    property p_reply_ack;
        @(posedge sys_clk) disable iff (reset)
        (pipe_word_fetch || block_word_fetch) |=> ##1 $changed(endpoint_return_bus[16]);
    endproperty
    a_reply_ack: assert property (p_reply_ack) else $error("no reply toggle");

    property p_empty_level;
        @(posedge sys_clk) disable iff (reset)
        fifo_empty_flag |-> fifo_fill_level == 4'h0 && !fifo_full_flag;
    endproperty
    a_empty_level: assert property (p_empty_level) else $error("empty with level");

    property p_full_level;
        @(posedge sys_clk) disable iff (reset)
        fifo_full_flag |-> fifo_fill_level == 4'hf && !fifo_empty_flag;
    endproperty
    a_full_level: assert property (p_full_level) else $error("full level wrong");
endmodule

// ==== endpoint_pkg.sv ====
// constants shared by the endpoint block and its fifo
// assumes a single 40 mhz sys_clk that also serves as the endpoint clock
package endpoint_pkg;
    // ****************************************
    // bus widths
    // ****************************************
    localparam int CTRL_W = 31;
    localparam int RET_W = 17;
    localparam int WORD_W = 16;
    localparam int TRIG_W = 16;
    localparam int LEVEL_W = 4;
    // ****************************************
    // control bus and return bus field positions
    // ****************************************
    localparam int TRIG_LSB = 0;
    localparam int ADDR_LSB = 16;
    localparam int ADDR_W = 8;
    localparam int PIPE_REQ_BIT = 24;
    localparam int BT_REQ_BIT = 25;
    localparam int BUF_REQ_BIT = 26;
    localparam int ACK_BIT = 16;
    // ****************************************
    // endpoint addresses and sizes
    // ****************************************
    localparam logic [7:0] PIPE_ADDR = 8'ha0;
    localparam logic [7:0] BT_ADDR = 8'ha1;
    localparam logic [7:0] BUF_ADDR = 8'ha2;
    localparam int FIFO_DEPTH = 8;
    localparam int LEVEL_STEPS = 16;
    localparam logic [3:0] BLOCK_WORDS = 4'h8;
    localparam logic [15:0] EMPTY_WORD = 16'h0000;
endpackage

// ==== fifo_if.sv ====
// signal bundle between the endpoint top and its word fifo
// both ends sit on sys_clk
`timescale 1ns/100ps
interface fifo_if;
    logic push;
    logic push_ready;
    logic [endpoint_pkg::WORD_W-1:0] push_data;
    logic pop;
    logic pop_valid;
    logic [endpoint_pkg::WORD_W-1:0] pop_data;
    logic full;
    logic empty;
    logic [endpoint_pkg::LEVEL_W-1:0] level;
    modport store (input push, push_data, pop, output push_ready, pop_valid, pop_data,
        full, empty, level);
    modport user (output push, push_data, pop, input push_ready, pop_valid, pop_data,
        full, empty, level);
endinterface

// ==== word_fifo.sv ====
// word fifo with registered read data and registered status
// assumes push and pop come from logic on sys_clk
`timescale 1ns/100ps
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic reset,
    fifo_if.store f
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic do_push;
    logic do_pop;
    logic [AW:0] next_count;
    logic [7:0] scaled;

    // a push into a full fifo is dropped, the word is lost
    assign do_push = f.push && (count < (AW+1)'(DEPTH));
    assign do_pop = f.pop && (count != '0);
    assign next_count = count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    assign scaled = 8'((32'(next_count) * endpoint_pkg::LEVEL_STEPS) / DEPTH);
    assign f.push_ready = !f.full;
    assign f.pop_valid = !f.empty;

    // ****************************************
    // storage
    // ****************************************
    always_ff @(posedge sys_clk)
    begin
        if (do_push)
        begin
            mem[wr_ptr] <= f.push_data;
        end
        f.pop_data <= mem[rd_ptr];
    end

    // ****************************************
    // pointers and status
    // ****************************************
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            f.full <= 1'b0;
            f.empty <= 1'b1;
            f.level <= '0;
        end
        else
        begin
            if (do_push)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= next_count;
            f.full <= next_count == (AW+1)'(DEPTH);
            f.empty <= next_count == '0;
            // top step saturates: a full fifo reads as fifteen sixteenths
            f.level <= (scaled > 8'h0f) ? 4'hf : scaled[3:0];
        end
    end

    property p_full_blocks;
        @(posedge sys_clk) disable iff (reset)
        f.full && f.push && !f.pop |=> f.full && $stable(wr_ptr);
    endproperty
    a_full_blocks: assert property (p_full_blocks) else $error("push into full fifo");

    property p_push_moves;
        @(posedge sys_clk) disable iff (reset)
        f.push && !f.full |=> wr_ptr == $past(wr_ptr) + 1'b1 && !f.empty;
    endproperty
    a_push_moves: assert property (p_push_moves) else $error("push did not advance");
endmodule

// ==== user_side_model.sv ====
// user-side model: hands pipe and block words to the endpoint block
// assumes fetch pulses arrive on sys_clk from the endpoint block
`timescale 1ns/100ps
module user_side_model (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic pipe_word_fetch,
    input wire logic block_word_fetch,
    input wire logic ready_en,
    output logic [15:0] pipe_word_in,
    output logic [15:0] block_word_in,
    output logic block_data_ready
);
    logic [15:0] pipe_next;
    logic [15:0] block_next;
    // ****
    // word supply
    // ****
    // off-cycle words invert each cycle so a late sample is caught
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            pipe_next <= 16'h1000;
            block_next <= 16'h2000;
            pipe_word_in <= 16'hffff;
            block_word_in <= 16'hffff;
        end
        else
        begin
            pipe_word_in <= pipe_word_fetch ? pipe_next : ~pipe_word_in;
            block_word_in <= block_word_fetch ? block_next : ~block_word_in;
            if (pipe_word_fetch)
                pipe_next <= pipe_next + 16'h0001;
            if (block_word_fetch)
                block_next <= block_next + 16'h0001;
        end
    end
    // ****
    // ready
    // ****
    always_ff @(posedge sys_clk)
    begin
        block_data_ready <= ~reset & ready_en;
    end
endmodule

// ==== testbench.sv ====
// testbench: triggers, plain, block and buffered pipes of the endpoint block
// assumes user_side_model supplies words; bench plays the host
`timescale 1ns/100ps
module testbench;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [30:0] host_ctrl_bus = 31'h0;
    logic [16:0] endpoint_return_bus;
    logic [15:0] host_trigger_bits;
    logic [15:0] pipe_word_in;
    logic pipe_word_fetch;
    logic [15:0] block_word_in;
    logic block_word_fetch;
    logic block_begin_pulse;
    logic block_data_ready;
    logic [15:0] fifo_word_in = 16'h0;
    logic fifo_push = 1'b0;
    logic fifo_full_flag;
    logic fifo_empty_flag;
    logic [3:0] fifo_fill_level;
    logic ready_en = 1'b1;
    logic last_ack = 1'b0;
    logic [15:0] last_word = 16'h0;
    int err_count = 0;
    int checks_done = 0;
    int fetch_n;
    int begin_n;
    always #12.5 sys_clk = ~sys_clk;
    host_endpoint_trigger_pipe_out dut_u (.sys_clk, .reset, .host_ctrl_bus,
        .endpoint_return_bus, .host_trigger_bits, .pipe_word_in, .pipe_word_fetch,
        .block_word_in, .block_word_fetch, .block_begin_pulse, .block_data_ready,
        .fifo_word_in, .fifo_push, .fifo_full_flag, .fifo_empty_flag, .fifo_fill_level);
    user_side_model model_u (.sys_clk, .reset, .pipe_word_fetch, .block_word_fetch,
        .ready_en, .pipe_word_in, .block_word_in, .block_data_ready);
    // ****
    // shared tasks
    // ****
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // address settles a few edges before the request toggle
    task automatic host_send(input logic [7:0] addr, input int req_bit);
        @(posedge sys_clk);
        host_ctrl_bus[23:16] <= addr;
        repeat (3) @(posedge sys_clk);
        host_ctrl_bus[req_bit] <= ~host_ctrl_bus[req_bit];
    endtask
    task automatic host_wait(input logic [15:0] exp, input int limit, input logic want);
        int n;
        fetch_n = 0;
        begin_n = 0;
        for (n = 0; n < limit; n++)
        begin
            @(posedge sys_clk);
            #1;
            fetch_n += int'(pipe_word_fetch === 1'b1) + int'(block_word_fetch === 1'b1);
            begin_n += int'(block_begin_pulse === 1'b1);
            if (endpoint_return_bus[16] !== last_ack)
                break;
        end
        check(16'(n < limit), 16'(want), "ack");
        check(endpoint_return_bus[15:0], want ? exp : last_word, "word");
        last_ack = endpoint_return_bus[16];
        if (want)
            last_word = exp;
    endtask
    // ****
    // scenarios
    // ****
    task automatic test_reset();
        @(posedge sys_clk);
        #1;
        check(host_trigger_bits, 16'h0, "trig");
        check(16'(fifo_empty_flag), 16'h1, "empty");
        check(16'(fifo_full_flag), 16'h0, "full");
        check(16'(fifo_fill_level), 16'h0, "level");
        $display("test reset done");
    endtask
    task automatic test_triggers();
        logic [15:0] masks [4] = '{16'h0001, 16'h0080, 16'h8000, 16'h8001};
        int n;
        foreach (masks[i])
        begin
            @(posedge sys_clk);
            host_ctrl_bus[15:0] <= host_ctrl_bus[15:0] ^ masks[i];
            for (n = 0; n < 12; n++)
            begin
                @(posedge sys_clk);
                #1;
                if (host_trigger_bits !== 16'h0)
                    break;
            end
            // pulse is due on the fifth edge after the toggle
            check(16'(n), 16'h4, "trig latency");
            check(host_trigger_bits, masks[i], "trig");
            @(posedge sys_clk);
            #1;
            check(host_trigger_bits, 16'h0, "trig pulse");
        end
        $display("test triggers done");
    endtask
    task automatic test_plain();
        host_send(8'h55, 24);
        host_wait(16'h0, 30, 1'b0);
        check(16'(fetch_n), 16'h0, "fetch");
        for (int i = 0; i < 2; i++)
        begin
            host_send(endpoint_pkg::PIPE_ADDR, 24);
            host_wait(16'h1000 + 16'(i), 40, 1'b1);
            check(16'(fetch_n), 16'h1, "fetch");
        end
        $display("test plain done");
    endtask
    task automatic test_block();
        @(posedge sys_clk);
        ready_en <= 1'b0;
        host_send(endpoint_pkg::BT_ADDR, 25);
        host_wait(16'h0, 20, 1'b0);
        check(16'(fetch_n), 16'h0, "held");
        ready_en <= 1'b1;
        host_wait(16'h2000, 40, 1'b1);
        check(16'(begin_n), 16'h1, "begin");
        for (int i = 1; i < 8; i++)
        begin
            host_send(endpoint_pkg::BT_ADDR, 25);
            host_wait(16'h2000 + 16'(i), 40, 1'b1);
            check(16'(begin_n * 2 + fetch_n), 16'h1, "block fetch");
        end
        $display("test block done");
    endtask
    task automatic test_fifo();
        int n;
        for (int i = 0; i < 9; i++)
        begin
            @(posedge sys_clk);
            fifo_word_in <= 16'h3000 + 16'(i);
            fifo_push <= 1'b1;
            @(posedge sys_clk);
            fifo_push <= 1'b0;
            repeat (2) @(posedge sys_clk);
            #1;
            n = (i < 8) ? i + 1 : 8;
            check(16'(fifo_fill_level), (n == 8) ? 16'hf : 16'(n * 2), "level");
            check(16'(fifo_full_flag), 16'(n == 8), "full");
            check(16'(fifo_empty_flag), 16'h0, "empty");
        end
        for (int i = 0; i < 9; i++)
        begin
            host_send(endpoint_pkg::BUF_ADDR, 26);
            host_wait((i < 8) ? 16'h3000 + 16'(i) : 16'h0, 40, 1'b1);
        end
        repeat (2) @(posedge sys_clk);
        #1;
        check(16'(fifo_empty_flag), 16'h1, "empty");
        check(16'(fifo_fill_level), 16'h0, "level");
        $display("test fifo done");
    endtask
    // ****
    // sequence and watchdog
    // ****
    initial
    begin
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        test_reset();
        test_triggers();
        test_plain();
        test_block();
        test_fifo();
        results();
    end
    // whole run is well under a thousand requests' worth of cycles
    initial
    begin
        #500000;
        err_count++;
        results();
    end
endmodule
